// ---- verilog/irq_prio_pkg.sv ----
`default_nettype none
package irq_prio_pkg;
	// ----------------------------------------------------------------
	// Register byte addresses on the APB window
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_PIE_ONE = 8'h00;
	localparam logic [7:0] ADDR_PIE_TWO = 8'h04;
	localparam logic [7:0] ADDR_IPR_ONE = 8'h08;
	localparam logic [7:0] ADDR_IPR_TWO = 8'h0C;
	localparam logic [7:0] ADDR_RST_CTRL = 8'h10;
	localparam logic [7:0] ADDR_MAIN_CTRL = 8'h14;
	localparam logic [7:0] ADDR_SECOND_CTRL = 8'h18;
	localparam logic [7:0] ADDR_THIRD_CTRL = 8'h1C;
	localparam logic [7:0] ADDR_PFLAG_ONE = 8'h20;
	localparam logic [7:0] ADDR_PFLAG_TWO = 8'h24;
	localparam logic [7:0] ADDR_CORE_CTRL = 8'h28;

	// ----------------------------------------------------------------
	// Reset values and implemented-bit masks
	// ----------------------------------------------------------------
	localparam logic [7:0] PIE_RST = 8'h00;
	localparam logic [7:0] IPR_RST = 8'hFF;
	localparam logic [7:0] TWO_MASK = 8'hDF;
	localparam logic [7:0] ONE_MASK_SMALL = 8'h7F;
	localparam logic [7:0] RSTCTL_RST = 8'h5C;
	localparam logic [7:0] RSTCTL_WMASK = 8'hD3;
	localparam logic [7:0] MAIN_RST = 8'h00;
	localparam logic [7:0] SECOND_RST = 8'hF5;
	localparam logic [7:0] SECOND_MASK = 8'hF5;
	localparam logic [7:0] THIRD_RST = 8'hC0;
	localparam logic [7:0] THIRD_MASK = 8'hDB;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int RC_PRIO_ON = 7;
	localparam int MC_GLOBAL_EN = 7;
	localparam int MC_GATE_EN = 6;
	localparam int MC_T0_EN = 5;
	localparam int MC_X0_EN = 4;
	localparam int MC_RB_EN = 3;
	localparam int MC_T0_FLAG = 2;
	localparam int MC_X0_FLAG = 1;
	localparam int MC_RB_FLAG = 0;
	localparam int SC_EDGE0 = 6;
	localparam int SC_EDGE1 = 5;
	localparam int SC_EDGE2 = 4;
	localparam int SC_T0_PRIO = 2;
	localparam int SC_RB_PRIO = 0;
	localparam int TC_X2_PRIO = 7;
	localparam int TC_X1_PRIO = 6;
	localparam int TC_X2_EN = 4;
	localparam int TC_X1_EN = 3;
	localparam int TC_X2_FLAG = 1;
	localparam int TC_X1_FLAG = 0;

	// Context captured on interrupt entry
	typedef struct packed {
		logic [20:0] ret_pc;
		logic [7:0] working;
		logic [7:0] status;
		logic [7:0] bank;
	} ctx_t;
endpackage
`default_nettype wire

// ---- verilog/peripheral_interrupt_priority_ctrl.sv ----
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module peripheral_interrupt_priority_ctrl #(
	parameter bit SMALL_PKG = 1'b0
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] pflag_one_set,
	input wire logic [7:0] pflag_two_set,
	input wire logic [2:0] ext_pin,
	input wire logic timer0_wrap8,
	input wire logic timer0_wrap16,
	input wire logic timer0_mode16,
	input wire logic [3:0] portb_upper,
	input wire logic core_sleeping,
	input wire logic irq_ack,
	input wire logic [20:0] ret_pc,
	input wire logic [7:0] working_register,
	input wire logic [7:0] status_register,
	input wire logic [7:0] bank_select_register,
	output logic irq_high,
	output logic irq_low,
	output logic wake_req,
	output logic vector_take,
	output irq_prio_pkg::ctx_t shadow_ctx,
	output logic [20:0] stack_top,
	output logic stack_push
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] pie_one_r, pie_two_r, ipr_one_r, ipr_two_r, rstctl_r;
	logic [7:0] main_r, second_r, third_r, pflag_one_r, pflag_two_r;
	logic [2:0] pin_d_r;
	logic [3:0] portb_d_r;
	logic wake_pend_r;
	logic wr;
	logic [2:0] edge_hit;
	logic [2:0] edge_sel;
	logic [1:0] x_prio;
	logic [7:0] one_mask;
	logic [7:0] wd;
	logic t0_hit, rb_hit;
	logic [7:0] p1_act, p2_act;
	logic per_any, per_hi, per_lo;
	logic core_any, core_hi, core_lo;
	logic hi_nxt, lo_nxt, any_en_pin, wake_hit;

	assign wr = psel && penable && pwrite;
	assign wd = pwdata[7:0];
	// Parallel-port bits vanish on the small package
	assign one_mask = SMALL_PKG ? irq_prio_pkg::ONE_MASK_SMALL : 8'hFF;

	// Write with hardware set winning over a software clear
	function automatic logic [7:0] upd(input logic [7:0] cur, input logic hit_w,
		input logic [7:0] data, input logic [7:0] mask, input logic [7:0] setv);
		logic [7:0] v;
		v = hit_w ? (data & mask) : cur;
		upd = (v | setv) & mask;
	endfunction

	// ----------------------------------------------------------------
	// Event detection
	// ----------------------------------------------------------------
	assign edge_sel = {second_r[irq_prio_pkg::SC_EDGE2], second_r[irq_prio_pkg::SC_EDGE1],
		second_r[irq_prio_pkg::SC_EDGE0]};
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_edge
			// Rising when select is 1, falling when 0
			assign edge_hit[g] = edge_sel[g] ? (ext_pin[g] & ~pin_d_r[g]) :
				(~ext_pin[g] & pin_d_r[g]);
		end
	endgenerate
	assign t0_hit = timer0_mode16 ? timer0_wrap16 : timer0_wrap8;
	assign rb_hit = |(portb_upper ^ portb_d_r);

	// Input history for edge and change detection
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_d_r <= 3'h0;
			portb_d_r <= 4'h0;
		end else begin
			pin_d_r <= ext_pin;
			portb_d_r <= portb_upper;
		end
	end

	// ----------------------------------------------------------------
	// Enable, priority and control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pie_one_r <= irq_prio_pkg::PIE_RST;
			pie_two_r <= irq_prio_pkg::PIE_RST;
			// Parallel-port priority must not start set on the small package
			ipr_one_r <= irq_prio_pkg::IPR_RST &
				(SMALL_PKG ? irq_prio_pkg::ONE_MASK_SMALL : 8'hFF);
			ipr_two_r <= irq_prio_pkg::IPR_RST & irq_prio_pkg::TWO_MASK;
			rstctl_r <= irq_prio_pkg::RSTCTL_RST;
		end else begin
			pie_one_r <= upd(pie_one_r, wr && paddr == irq_prio_pkg::ADDR_PIE_ONE,
				wd, one_mask, 8'h00);
			pie_two_r <= upd(pie_two_r, wr && paddr == irq_prio_pkg::ADDR_PIE_TWO,
				wd, irq_prio_pkg::TWO_MASK, 8'h00);
			ipr_one_r <= upd(ipr_one_r, wr && paddr == irq_prio_pkg::ADDR_IPR_ONE,
				wd, one_mask, 8'h00);
			ipr_two_r <= upd(ipr_two_r, wr && paddr == irq_prio_pkg::ADDR_IPR_TWO,
				wd, irq_prio_pkg::TWO_MASK, 8'h00);
			// Watchdog and power-down flags keep their value on writes
			if (wr && paddr == irq_prio_pkg::ADDR_RST_CTRL) begin
				rstctl_r <= (wd & irq_prio_pkg::RSTCTL_WMASK) |
					(rstctl_r & ~irq_prio_pkg::RSTCTL_WMASK);
			end
		end
	end

	// Main, second and third control; main and third carry hardware-set flags
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			main_r <= irq_prio_pkg::MAIN_RST;
			second_r <= irq_prio_pkg::SECOND_RST;
			third_r <= irq_prio_pkg::THIRD_RST;
		end else begin
			main_r <= upd(main_r, wr && paddr == irq_prio_pkg::ADDR_MAIN_CTRL, wd, 8'hFF,
				{5'h00, t0_hit, edge_hit[0], rb_hit});
			second_r <= upd(second_r, wr && paddr == irq_prio_pkg::ADDR_SECOND_CTRL, wd,
				irq_prio_pkg::SECOND_MASK, 8'h00);
			third_r <= upd(third_r, wr && paddr == irq_prio_pkg::ADDR_THIRD_CTRL, wd,
				irq_prio_pkg::THIRD_MASK, {6'h00, edge_hit[2:1]});
		end
	end

	// Peripheral flags; capcmp1 capture/compare arrives on its set line
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pflag_one_r <= 8'h00;
			pflag_two_r <= 8'h00;
		end else begin
			pflag_one_r <= upd(pflag_one_r, wr && paddr == irq_prio_pkg::ADDR_PFLAG_ONE,
				wd, one_mask, pflag_one_set);
			pflag_two_r <= upd(pflag_two_r, wr && paddr == irq_prio_pkg::ADDR_PFLAG_TWO,
				wd, irq_prio_pkg::TWO_MASK, pflag_two_set);
		end
	end

	// ----------------------------------------------------------------
	// Request routing
	// ----------------------------------------------------------------
	assign p1_act = pflag_one_r & pie_one_r;
	assign p2_act = pflag_two_r & pie_two_r;
	assign per_any = |{p1_act, p2_act};
	assign per_hi = |{p1_act & ipr_one_r, p2_act & ipr_two_r};
	assign per_lo = |{p1_act & ~ipr_one_r, p2_act & ~ipr_two_r};
	assign x_prio = {third_r[irq_prio_pkg::TC_X2_PRIO], third_r[irq_prio_pkg::TC_X1_PRIO]};
	// Core sources: pin0 always high; disabled pins raise nothing
	assign core_hi = (main_r[irq_prio_pkg::MC_X0_FLAG] && main_r[irq_prio_pkg::MC_X0_EN]) ||
		(third_r[irq_prio_pkg::TC_X1_FLAG] && third_r[irq_prio_pkg::TC_X1_EN] && x_prio[0]) ||
		(third_r[irq_prio_pkg::TC_X2_FLAG] && third_r[irq_prio_pkg::TC_X2_EN] && x_prio[1]) ||
		(main_r[irq_prio_pkg::MC_T0_FLAG] && main_r[irq_prio_pkg::MC_T0_EN] &&
		second_r[irq_prio_pkg::SC_T0_PRIO]) ||
		(main_r[irq_prio_pkg::MC_RB_FLAG] && main_r[irq_prio_pkg::MC_RB_EN] &&
		second_r[irq_prio_pkg::SC_RB_PRIO]);
	assign core_any = (main_r[irq_prio_pkg::MC_X0_FLAG] && main_r[irq_prio_pkg::MC_X0_EN]) ||
		(third_r[irq_prio_pkg::TC_X1_FLAG] && third_r[irq_prio_pkg::TC_X1_EN]) ||
		(third_r[irq_prio_pkg::TC_X2_FLAG] && third_r[irq_prio_pkg::TC_X2_EN]) ||
		(main_r[irq_prio_pkg::MC_T0_FLAG] && main_r[irq_prio_pkg::MC_T0_EN]) ||
		(main_r[irq_prio_pkg::MC_RB_FLAG] && main_r[irq_prio_pkg::MC_RB_EN]);
	assign core_lo = core_any && !core_hi;
	assign any_en_pin = main_r[irq_prio_pkg::MC_X0_EN] || third_r[irq_prio_pkg::TC_X1_EN] ||
		third_r[irq_prio_pkg::TC_X2_EN];

	// Bit 7 of main control is the global (or high) enable, bit 6 the peripheral (or low) gate
	always_comb begin
		if (rstctl_r[irq_prio_pkg::RC_PRIO_ON]) begin
			hi_nxt = main_r[irq_prio_pkg::MC_GLOBAL_EN] && (core_hi || per_hi);
			lo_nxt = main_r[irq_prio_pkg::MC_GLOBAL_EN] && main_r[irq_prio_pkg::MC_GATE_EN] &&
				(core_lo || per_lo);
		end else begin
			// Single level: everything goes out as the high request
			hi_nxt = main_r[irq_prio_pkg::MC_GLOBAL_EN] && (core_any ||
				(per_any && main_r[irq_prio_pkg::MC_GATE_EN]));
			lo_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_high <= 1'b0;
			irq_low <= 1'b0;
		end else begin
			irq_high <= hi_nxt;
			irq_low <= lo_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Wake-up from idle or sleep
	// ----------------------------------------------------------------
	// An edge wakes only through a pin whose own enable is set
	assign wake_hit = (edge_hit[0] && main_r[irq_prio_pkg::MC_X0_EN]) ||
		(edge_hit[1] && third_r[irq_prio_pkg::TC_X1_EN]) ||
		(edge_hit[2] && third_r[irq_prio_pkg::TC_X2_EN]);

	// Pin events count only if some pin enable was set a cycle earlier, so a late first enable cannot wake
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wake_pend_r <= 1'b0;
			wake_req <= 1'b0;
			vector_take <= 1'b0;
		end else begin
			wake_pend_r <= core_sleeping && any_en_pin;
			wake_req <= core_sleeping && wake_pend_r && wake_hit;
			// A disabled pin must not send the core to the vector either
			vector_take <= core_sleeping && wake_pend_r && wake_hit &&
				main_r[irq_prio_pkg::MC_GLOBAL_EN];
		end
	end

	// ----------------------------------------------------------------
	// Context capture on entry
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			shadow_ctx <= '0;
			stack_top <= 21'h00000;
			stack_push <= 1'b0;
		end else begin
			stack_push <= irq_ack;
			if (irq_ack) begin
				stack_top <= ret_pc;
				shadow_ctx <= '{ret_pc, working_register, status_register,
					bank_select_register};
			end
		end
	end

	// ----------------------------------------------------------------
	// APB read path, zero-wait
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				case (paddr)
					irq_prio_pkg::ADDR_PIE_ONE: prdata <= {24'h0, pie_one_r};
					irq_prio_pkg::ADDR_PIE_TWO: prdata <= {24'h0, pie_two_r};
					irq_prio_pkg::ADDR_IPR_ONE: prdata <= {24'h0, ipr_one_r};
					irq_prio_pkg::ADDR_IPR_TWO: prdata <= {24'h0, ipr_two_r};
					irq_prio_pkg::ADDR_RST_CTRL: prdata <= {24'h0, rstctl_r};
					irq_prio_pkg::ADDR_MAIN_CTRL: prdata <= {24'h0, main_r};
					irq_prio_pkg::ADDR_SECOND_CTRL: prdata <= {24'h0, second_r};
					irq_prio_pkg::ADDR_THIRD_CTRL: prdata <= {24'h0, third_r};
					irq_prio_pkg::ADDR_PFLAG_ONE: prdata <= {24'h0, pflag_one_r};
					irq_prio_pkg::ADDR_PFLAG_TWO: prdata <= {24'h0, pflag_two_r};
					default: begin
						prdata <= 32'h00000000;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_gate_closed;
		@(posedge clk_sys) disable iff (rst)
		(!rstctl_r[irq_prio_pkg::RC_PRIO_ON] && !main_r[irq_prio_pkg::MC_GATE_EN] && !core_any)
		|=> !irq_high;
	endproperty
	a_gate_closed: assert property (p_gate_closed) else $error("peripheral passed closed gate");
	property p_no_low_single;
		@(posedge clk_sys) disable iff (rst) !rstctl_r[irq_prio_pkg::RC_PRIO_ON] |=> !irq_low;
	endproperty
	a_no_low_single: assert property (p_no_low_single) else $error("low request in single mode");
	property p_bit5_zero;
		@(posedge clk_sys) disable iff (rst) !pie_two_r[5] && !ipr_two_r[5];
	endproperty
	a_bit5_zero: assert property (p_bit5_zero) else $error("bit 5 not zero");
	property p_small_pkg;
		@(posedge clk_sys) disable iff (rst) SMALL_PKG |-> !pie_one_r[7] && !ipr_one_r[7];
	endproperty
	a_small_pkg: assert property (p_small_pkg) else $error("parallel bit set on small package");
	property p_edge_flag;
		@(posedge clk_sys) disable iff (rst) edge_hit[0] |=> main_r[1];
	endproperty
	a_edge_flag: assert property (p_edge_flag) else $error("pin0 edge lost");
	property p_t0_flag;
		@(posedge clk_sys) disable iff (rst) t0_hit |=> main_r[2];
	endproperty
	a_t0_flag: assert property (p_t0_flag) else $error("timer0 overflow lost");
	property p_rb_flag;
		@(posedge clk_sys) disable iff (rst) $changed(portb_d_r) |-> main_r[0];
	endproperty
	a_rb_flag: assert property (p_rb_flag) else $error("port-b change lost");
	property p_poll;
		@(posedge clk_sys) disable iff (rst) pflag_one_set[2] |=> pflag_one_r[2];
	endproperty
	a_poll: assert property (p_poll) else $error("capcmp1 flag lost");
	property p_ctx;
		@(posedge clk_sys) disable iff (rst)
		irq_ack |=> stack_push && shadow_ctx.working == $past(working_register);
	endproperty
	a_ctx: assert property (p_ctx) else $error("context not saved");
	property p_ro_flags;
		@(posedge clk_sys) disable iff (rst) ##1 rstctl_r[3:2] == $past(rstctl_r[3:2]);
	endproperty
	a_ro_flags: assert property (p_ro_flags) else $error("read-only flag changed");
endmodule
`default_nettype wire

// ---- dv/core_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Core model: takes a request after a programmable stall
// ----------------------------------------------------------------
module core_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic irq_high,
	input wire logic irq_low,
	input wire logic [3:0] stall,
	output logic irq_ack,
	output logic [44:0] core_vals,
	output logic [44:0] acked_vals
);
	logic [3:0] wait_r;
	logic busy_r;

	// Core state moves every cycle, so a sample off the ack edge shows up
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			core_vals <= 45'h0;
		end else begin
			core_vals <= 45'({$urandom, $urandom});
		end
	end

	// One entry per request; re-armed only once the request drops
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_ack <= 1'h0;
			busy_r <= 1'h0;
			wait_r <= 4'h0;
			acked_vals <= 45'h0;
		end else begin
			irq_ack <= 1'h0;
			if (irq_ack) begin
				acked_vals <= core_vals; // Value the block sampled at the ack edge
			end
			if (!(irq_high || irq_low)) begin
				busy_r <= 1'h0;
				wait_r <= 4'h0;
			end else if (!busy_r && wait_r == stall) begin
				irq_ack <= 1'h1;
				busy_r <= 1'h1;
			end else if (!busy_r) begin
				wait_r <= wait_r + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- dv/peripheral_interrupt_priority_ctrl_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module peripheral_interrupt_priority_ctrl_bench;
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, prdata_small;
	logic pready, pslverr, irq_ack, irq_high, irq_low, wake_req, vector_take, stack_push;
	logic [7:0] pflag_one_set = 8'h00, pflag_two_set = 8'h00;
	logic [2:0] ext_pin = 3'h0;
	logic timer0_wrap8 = 1'h0, timer0_wrap16 = 1'h0, timer0_mode16 = 1'h0;
	logic core_sleeping = 1'h0;
	logic [3:0] portb_upper = 4'h0, stall = 4'h0;
	logic [44:0] core_vals, acked_vals;
	irq_prio_pkg::ctx_t shadow_ctx;
	logic [20:0] stack_top;
	logic [9:0] notes[$];
	logic [9:0] nq;
	logic [7:0] fb, ra, base;
	logic [7:0] rv [10] = '{8'h00, 8'h00, 8'hFF, 8'hDF, 8'h5C, 8'h00, 8'hF5, 8'hC0, 8'h00, 8'h00};
	logic [7:0] wm [5] = '{8'hFF, 8'hDF, 8'hFF, 8'hDF, 8'hD3};
	int bad_count = 0, checks_done = 0, cyc = 0;
	int wake_n = 0, vec_n = 0, ack_n = 0, push_n = 0;
	int i, p, e, m, k;

	always #5 clk_sys = ~clk_sys;

	peripheral_interrupt_priority_ctrl #(.SMALL_PKG(1'h0)) u_dut (
		.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.pflag_one_set, .pflag_two_set, .ext_pin, .timer0_wrap8, .timer0_wrap16, .timer0_mode16,
		.portb_upper, .core_sleeping, .irq_ack, .ret_pc(core_vals[44:24]),
		.working_register(core_vals[23:16]), .status_register(core_vals[15:8]),
		.bank_select_register(core_vals[7:0]), .irq_high, .irq_low, .wake_req, .vector_take,
		.shadow_ctx, .stack_top, .stack_push);

	// Small-package variant on the same bus; only its read data is watched
	peripheral_interrupt_priority_ctrl #(.SMALL_PKG(1'h1)) u_dut_small (
		.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(prdata_small),
		.pready(), .pslverr(), .pflag_one_set, .pflag_two_set, .ext_pin, .timer0_wrap8,
		.timer0_wrap16, .timer0_mode16, .portb_upper, .core_sleeping, .irq_ack,
		.ret_pc(core_vals[44:24]), .working_register(core_vals[23:16]),
		.status_register(core_vals[15:8]), .bank_select_register(core_vals[7:0]),
		.irq_high(), .irq_low(), .wake_req(), .vector_take(), .shadow_ctx(), .stack_top(),
		.stack_push());

	core_model u_core (.clk_sys, .rst, .irq_high, .irq_low, .stall, .irq_ack, .core_vals,
		.acked_vals);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [44:0] got, input logic [44:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// APB transfer; the expected answer is noted for the scoreboard
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] x, input logic err);
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		notes.push_back({wr, err, x});
		@(posedge clk_sys);
		penable <= 1'h1;
		@(posedge clk_sys);
		while (pready !== 1'h1) @(posedge clk_sys);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic irqs(input logic [1:0] x);
		tick(3);
		chk(45'({irq_high, irq_low}), 45'(x));
	endtask

	task automatic pw(input logic [1:0] t);
		@(posedge clk_sys);
		{timer0_wrap16, timer0_wrap8} <= t;
		@(posedge clk_sys);
		{timer0_wrap16, timer0_wrap8} <= 2'h0;
	endtask

	// Scoreboard: each completed transfer retires the oldest note
	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'h1) begin
			nq = notes.pop_front();
			chk(45'({pslverr, nq[9] ? nq[7:0] : prdata[7:0]}), 45'(nq[8:0]));
			// Parallel-port enable and priority must read zero on the small package
			if (!pwrite && (paddr == 8'h00 || paddr == 8'h08)) begin
				chk(45'(prdata_small[7]), 45'h0);
			end
		end
	end

	// Pulse counters and the hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (wake_req === 1'h1) wake_n++;
		if (vector_take === 1'h1) vec_n++;
		if (irq_ack === 1'h1) ack_n++;
		if (stack_push === 1'h1) push_n++;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		k = $urandom(32'hA52CD8CD);
		tick(8);
		rst <= 1'h0;
		for (i = 0; i < 10; i++) apb(1'h0, 8'(i * 4), 8'h00, rv[i], 1'h0);
		apb(1'h1, 8'h30, 8'hFF, 8'h00, 1'h1);
		apb(1'h0, 8'h30, 8'h00, 8'h00, 1'h1);
		// Random write and read back; read-only reset-cause bits stay set
		for (i = 0; i < 15; i++) begin
			k = i % 5;
			fb = 8'($urandom);
			apb(1'h1, 8'(k * 4), fb, 8'h00, 1'h0);
			apb(1'h0, 8'(k * 4), 8'h00, (fb & wm[k]) | (k == 4 ? 8'h0C : 8'h00), 1'h0);
		end
		for (i = 0; i < 5; i++) apb(1'h1, 8'(i * 4), (i == 2 || i == 3) ? 8'hFF : 8'h00, 8'h00, 1'h0);
		// Peripheral gating and routing; the core stalls a random time
		for (m = 0; m < 2; m++) begin
			k = m ? ($urandom % 7) : 2;
			if (k == 5) k = 7;
			fb = 8'h01 << k;
			stall <= 4'($urandom);
			apb(1'h1, 8'(m * 4), fb, 8'h00, 1'h0);
			@(posedge clk_sys) {pflag_two_set, pflag_one_set} <= 16'(fb) << (m * 8);
			@(posedge clk_sys) {pflag_two_set, pflag_one_set} <= 16'h0;
			tick(3);
			apb(1'h0, 8'h20 + 8'(m * 4), 8'h00, fb, 1'h0);
			irqs(2'h0);
			apb(1'h1, 8'h14, 8'h80, 8'h00, 1'h0);
			irqs(2'h0);
			apb(1'h1, 8'h14, 8'hC0, 8'h00, 1'h0);
			irqs(2'h2);
			apb(1'h1, 8'h08 + 8'(m * 4), ~fb, 8'h00, 1'h0);
			irqs(2'h2);
			apb(1'h1, 8'h10, 8'h80, 8'h00, 1'h0);
			irqs(2'h1);
			apb(1'h1, 8'h08 + 8'(m * 4), 8'hFF, 8'h00, 1'h0);
			irqs(2'h2);
			apb(1'h1, 8'h14, 8'h00, 8'h00, 1'h0);
			apb(1'h1, 8'h10, 8'h00, 8'h00, 1'h0);
			apb(1'h1, 8'h20 + 8'(m * 4), 8'h00, 8'h00, 1'h0);
			apb(1'h1, 8'(m * 4), 8'h00, 8'h00, 1'h0);
			tick(12);
			chk(45'(shadow_ctx), acked_vals);
			chk(45'(stack_top), 45'(acked_vals[44:24]));
		end
		// External pins, both edge senses; pin 1 is set to low priority
		apb(1'h1, 8'h10, 8'h80, 8'h00, 1'h0);
		for (p = 0; p < 3; p++) begin
			for (e = 0; e < 2; e++) begin
				ra = p ? 8'h1C : 8'h14;
				base = p ? 8'h80 : 8'hC0;
				apb(1'h1, 8'h18, 8'h05 | (8'(e) << (6 - p)), 8'h00, 1'h0);
				@(posedge clk_sys) ext_pin[p] <= ~e[0];
				tick(3);
				apb(1'h1, ra, base, 8'h00, 1'h0);
				apb(1'h1, 8'h14, 8'hC0, 8'h00, 1'h0);
				@(posedge clk_sys) ext_pin[p] <= e[0];
				tick(3);
				apb(1'h0, ra, 8'h00, base | (8'h01 << (p != 1)), 1'h0);
				irqs(2'h0);
				apb(1'h1, ra, base | (8'h08 << (p != 1)) | (8'h01 << (p != 1)), 8'h00, 1'h0);
				irqs(p == 1 ? 2'h1 : 2'h2);
				apb(1'h1, ra, base, 8'h00, 1'h0);
				@(posedge clk_sys) ext_pin[p] <= ~e[0];
				tick(3);
				apb(1'h0, ra, 8'h00, base, 1'h0);
			end
		end
		// Wake from sleep: without and with global enable, then disabled
		apb(1'h1, 8'h10, 8'h00, 8'h00, 1'h0);
		apb(1'h1, 8'h18, 8'h45, 8'h00, 1'h0);
		@(posedge clk_sys) ext_pin <= 3'h0;
		core_sleeping <= 1'h1;
		for (m = 0; m < 3; m++) begin
			apb(1'h1, 8'h14, m == 0 ? 8'h10 : (m == 1 ? 8'h90 : 8'h00), 8'h00, 1'h0);
			tick(2);
			@(posedge clk_sys) ext_pin[0] <= 1'h1;
			tick(4);
			@(posedge clk_sys) ext_pin[0] <= 1'h0;
			tick(2);
			chk(45'(wake_n), 45'(m ? 2 : 1));
			chk(45'(vec_n), 45'(m ? 1 : 0));
		end
		core_sleeping <= 1'h0;
		// Timer wrap in both widths, then port change
		apb(1'h1, 8'h10, 8'h80, 8'h00, 1'h0);
		apb(1'h1, 8'h18, 8'h01, 8'h00, 1'h0);
		apb(1'h1, 8'h14, 8'hE0, 8'h00, 1'h0);
		for (m = 0; m < 2; m++) begin
			@(posedge clk_sys) timer0_mode16 <= m[0];
			pw(m ? 2'h1 : 2'h2);
			tick(3);
			apb(1'h0, 8'h14, 8'h00, 8'hE0, 1'h0);
			pw(m ? 2'h2 : 2'h1);
			tick(3);
			apb(1'h0, 8'h14, 8'h00, 8'hE4, 1'h0);
			irqs(2'h1);
			apb(1'h1, 8'h14, 8'hE0, 8'h00, 1'h0);
		end
		apb(1'h1, 8'h18, 8'h04, 8'h00, 1'h0);
		apb(1'h1, 8'h14, 8'hC8, 8'h00, 1'h0);
		@(posedge clk_sys) portb_upper <= 4'($urandom) | 4'h1;
		tick(3);
		apb(1'h0, 8'h14, 8'h00, 8'hC9, 1'h0);
		irqs(2'h1);
		apb(1'h1, 8'h14, 8'h00, 8'h00, 1'h0);
		tick(12);
		chk(45'(push_n), 45'(ack_n));
		give_verdict();
	end
endmodule
`default_nettype wire
